/* File: rdsbuf_top.v */
// Purpose: Block buffer, request line and serial readout port
// Assumes: Serial pins asynchronous to clk, decoder on clk
// Notes:   Request line is open drain, oe high pulls it low
`timescale 1ns/1ps
`default_nettype none
`include "rdsbuf_consts.vh"

// ----------------------------------------------------------------
// Input FIFO between decoder and block store
// ----------------------------------------------------------------
module rdsbuf_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             nrst,
    // Fill side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready,
    // Drain side
    output wire             out_valid,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      cnt_reg;
    reg [AW:0]      cnt_next;
    wire            push;
    wire            pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];

    always @* begin
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Full flag is registered so ready never depends on out_ready
    always @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {(AW+1){1'b0}};
            in_ready   <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            in_ready <= (cnt_next != DEPTH[AW:0]);
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // rdsbuf_fifo

// Functional notes
// RULE_01 - Eight address bits pick device and direction
// RULE_02 - Store holds at most 24 decoded blocks
// RULE_03 - Stored block pulls request line low
// RULE_04 - Release line high 265 us after readout
// RULE_05 - Empty store keeps line high until block; sync found still moves to R_REQ and pulls it low with the store empty
// RULE_06 - Unread blocks pull line low after release
// RULE_07 - After sync reset, high until sync found
// RULE_08 - Request after empty never overwritten within 480 ms
// RULE_09 - Request after release keeps data 20 ms
// RULE_10 - Host keeps strobe high under 20 ms
// RULE_11 - Readout without pending request gives zeros
// RULE_12 - Host treats early fall as other device
// RULE_13 - Host prefers embedded flags over line level
// RULE_14 - Ignore serial bus until oscillator runs
// RULE_15 - High threshold setting waits for 12 blocks
// RULE_16 - Shifted block is removed, read position advances
module rdsbuf_top #(
    parameter TDO_CYC = `RB_TDO_CYC
) (
    // Clock and reset
    input  wire                  clk,
    input  wire                  nrst,
    // Serial bus pins
    input  wire                  transfer_enable,
    input  wire                  serial_shift_clock,
    input  wire                  serial_input_line,
    output reg                   request_line_o,
    output reg                   request_line_oe,
    // Decoded block stream
    input  wire                  blk_valid,
    input  wire [`RB_DATA_W-1:0] blk_data,
    output wire                  blk_ready,
    // Decoder status
    input  wire                  osc_running,
    input  wire                  sync_reset,
    input  wire                  sync_found,
    // Request threshold straps
    input  wire                  request_threshold_select_low,
    input  wire                  request_threshold_select_high,
    // Store level
    output reg  [`RB_PTR_W-1:0]  level_out
);
    // ------------------------------------------------------------
    // Request line states
    // ------------------------------------------------------------
    localparam [2:0] R_UNSYNC = 3'h0;
    localparam [2:0] R_WAIT   = 3'h1;
    localparam [2:0] R_REQ    = 3'h2;
    localparam [2:0] R_READ   = 3'h3;
    localparam [2:0] R_REL    = 3'h4;
    localparam [31:0]          TDO_M1   = TDO_CYC - 1;
    localparam [`RB_TMR_W-1:0] TDO_LAST = TDO_M1[`RB_TMR_W-1:0];

    function [`RB_PTR_W-1:0] rb_inc;
        input [`RB_PTR_W-1:0] p;
        begin
            rb_inc = (p == `RB_LAST_IDX) ? {`RB_PTR_W{1'b0}} : p + 1'b1;
        end
    endfunction

    function rb_hit;
        input [`RB_ADDR_W-1:0]     a;
        input [`RB_ADDR_CNT_W-1:0] n;
        input [`RB_ADDR_W-1:0]     t;
        begin
            rb_hit = (n == `RB_ADDR_W) && (a == t);
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [3:0] pin_raw;
    wire [3:0] pin_s;
    assign pin_raw = {osc_running, serial_input_line,
                      serial_shift_clock, transfer_enable};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            reg s1_reg;
            reg s2_reg;
            always @(posedge clk) begin
                if (!nrst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_raw[gi];
                    s2_reg <= s1_reg;
                end
            end
            assign pin_s[gi] = s2_reg;
        end
    endgenerate

    reg  ce_d_reg;
    reg  cl_d_reg;
    wire ce_rise;
    wire ce_fall;
    wire cl_rise;
    wire cl_fall;
    assign ce_rise = pin_s[0] && !ce_d_reg;
    assign ce_fall = !pin_s[0] && ce_d_reg;
    assign cl_rise = pin_s[1] && !cl_d_reg;
    assign cl_fall = !pin_s[1] && cl_d_reg;

    // ------------------------------------------------------------
    // Input FIFO and block store
    // ------------------------------------------------------------
    wire                  f_valid;
    wire [`RB_DATA_W-1:0] f_data;
    wire                  f_ready;
    wire                  store;
    wire                  pop;
    reg  [`RB_DATA_W-1:0] mem [0:`RB_DEPTH-1];
    reg  [`RB_PTR_W-1:0]  wr_ptr_reg;
    reg  [`RB_PTR_W-1:0]  rd_ptr_reg;
    reg  [`RB_PTR_W-1:0]  level_reg;
    reg  [`RB_PTR_W-1:0]  level_next;
    wire [`RB_PTR_W-1:0]  thr;

    rdsbuf_fifo #(
        .WIDTH (`RB_DATA_W),
        .DEPTH (`RB_FIFO_DEPTH),
        .AW    (`RB_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (blk_valid),
        .in_data   (blk_data),
        .in_ready  (blk_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // Full store refuses new blocks, so a requested block survives
    assign f_ready = (level_reg != `RB_DEPTH) && !pop; // [RULE_02] [RULE_08] [RULE_09]
    assign store   = f_valid && f_ready;
    assign thr     = (request_threshold_select_low &&
                      request_threshold_select_high) ?
                     `RB_THR_HIGH : `RB_THR_ONE; // [RULE_15]

    always @* begin
        level_next = level_reg;
        if (store) begin
            level_next = level_reg + 1'b1;
        end else if (pop) begin
            level_next = level_reg - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (store) begin
            mem[wr_ptr_reg] <= f_data;
        end
    end

    // ------------------------------------------------------------
    // Address phase and readout shifter
    // ------------------------------------------------------------
    reg [`RB_ADDR_W-1:0]     addr_reg;
    reg [`RB_ADDR_CNT_W-1:0] addr_cnt_reg;
    reg                      reading_reg;
    reg                      real_reg;
    reg [`RB_FRAME_W-1:0]    sh_reg;
    reg [`RB_BIT_CNT_W-1:0]  bit_cnt_reg;
    reg [2:0]                state_reg;
    reg [2:0]                state_next;
    reg [`RB_TMR_W-1:0]      tmr_reg;
    wire                     rd_start;
    wire                     frame_end;
    wire [`RB_PTR_W-1:0]     left;

    // Bus traffic before the oscillator runs is not decoded
    assign rd_start  = ce_rise && pin_s[3] &&
                       rb_hit(addr_reg, addr_cnt_reg, `RB_ADDR_RD); // [RULE_01] [RULE_14]
    assign frame_end = reading_reg && pin_s[0] && cl_fall &&
                       (bit_cnt_reg == `RB_LAST_BIT);
    assign pop       = frame_end && real_reg; // [RULE_16]
    assign left      = level_reg - 1'b1;

    always @(posedge clk) begin
        if (!nrst) begin
            ce_d_reg     <= 1'b0;
            cl_d_reg     <= 1'b0;
            addr_reg     <= {`RB_ADDR_W{1'b0}};
            addr_cnt_reg <= {`RB_ADDR_CNT_W{1'b0}};
            reading_reg  <= 1'b0;
            real_reg     <= 1'b0;
            sh_reg       <= {`RB_FRAME_W{1'b0}};
            bit_cnt_reg  <= {`RB_BIT_CNT_W{1'b0}};
            wr_ptr_reg   <= {`RB_PTR_W{1'b0}};
            rd_ptr_reg   <= {`RB_PTR_W{1'b0}};
            level_reg    <= {`RB_PTR_W{1'b0}};
        end else begin
            ce_d_reg  <= pin_s[0];
            cl_d_reg  <= pin_s[1];
            level_reg <= level_next;
            if (store) begin
                wr_ptr_reg <= rb_inc(wr_ptr_reg);
            end
            if (!pin_s[0]) begin
                // Address bits, LSB first, while the strobe is low
                reading_reg <= 1'b0;
                if (ce_fall) begin
                    addr_cnt_reg <= {`RB_ADDR_CNT_W{1'b0}};
                end else if (cl_rise && pin_s[3] &&
                             addr_cnt_reg != `RB_ADDR_W) begin
                    addr_reg     <= {pin_s[2], addr_reg[`RB_ADDR_W-1:1]}; // [RULE_01]
                    addr_cnt_reg <= addr_cnt_reg + 1'b1;
                end
            end else if (rd_start) begin
                // Write transfers are accepted but carry nothing here
                reading_reg <= 1'b1;
                bit_cnt_reg <= {`RB_BIT_CNT_W{1'b0}};
                if (state_reg == R_REQ && level_reg != 5'h00) begin
                    real_reg <= 1'b1;
                    sh_reg   <= {left == 5'h00, left >= `RB_THR_HIGH,
                                 mem[rd_ptr_reg]};
                end else begin
                    real_reg <= 1'b0;
                    sh_reg   <= {`RB_FRAME_W{1'b0}}; // [RULE_11]
                end
            end else if (reading_reg && cl_fall) begin
                if (frame_end) begin
                    bit_cnt_reg <= {`RB_BIT_CNT_W{1'b0}};
                    if (real_reg) begin
                        // Next block follows in the same transfer
                        rd_ptr_reg <= rb_inc(rd_ptr_reg); // [RULE_16]
                        if (left != 5'h00) begin
                            sh_reg <= {left == 5'h01,
                                       left > `RB_THR_HIGH,
                                       mem[rb_inc(rd_ptr_reg)]};
                        end else begin
                            real_reg <= 1'b0;
                            sh_reg   <= {`RB_FRAME_W{1'b0}}; // [RULE_11]
                        end
                    end
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    sh_reg      <= {sh_reg[`RB_FRAME_W-2:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Request line control
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            R_UNSYNC: begin
                if (sync_found) begin
                    state_next = R_REQ; // [RULE_07]
                end
            end
            R_WAIT: begin
                if (rd_start) begin
                    state_next = R_READ;
                end else if (level_reg >= thr) begin
                    state_next = R_REQ; // [RULE_03] [RULE_05] [RULE_15]
                end
            end
            R_REQ: begin
                if (rd_start) begin
                    state_next = R_READ;
                end
            end
            R_READ: begin
                if (ce_fall) begin
                    state_next = R_REL; // [RULE_04]
                end
            end
            R_REL: begin
                if (rd_start) begin
                    state_next = R_READ;
                end else if (tmr_reg == TDO_LAST) begin
                    state_next = (level_reg >= thr) ? R_REQ : R_WAIT; // [RULE_06] [RULE_05]
                end
            end
            default: begin
                state_next = R_UNSYNC;
            end
        endcase
        // A sync reset outranks every other state change
        if (sync_reset) begin
            state_next = R_UNSYNC; // [RULE_07]
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_reg       <= R_UNSYNC;
            tmr_reg         <= {`RB_TMR_W{1'b0}};
            request_line_o  <= 1'b0;
            request_line_oe <= 1'b0;
            level_out       <= {`RB_PTR_W{1'b0}};
        end else begin
            state_reg <= state_next;
            level_out <= level_reg;
            if (state_reg == R_REL) begin
                tmr_reg <= tmr_reg + 1'b1; // [RULE_04]
            end else begin
                tmr_reg <= {`RB_TMR_W{1'b0}};
            end
            // Readout data while strobe high, else the request level;
            // an unsynchronised readout still shifts its zero frame
            if ((state_next == R_READ || reading_reg) && pin_s[0]) begin
                request_line_oe <= !sh_reg[`RB_FRAME_W-1]; // [RULE_11]
            end else begin
                request_line_oe <= (state_next == R_REQ); // [RULE_03]
            end
        end
    end
endmodule // rdsbuf_top

`default_nettype wire

/* File: rdsbuf_consts.vh */
// Purpose: Shared constants of the block buffer serial readout
// Assumes: 125 MHz core clock, 16-bit decoded blocks
// Notes:   Definitions only, no logic
`ifndef RDSBUF_CONSTS_VH
`define RDSBUF_CONSTS_VH

// ----------------------------------------------------------------
// Serial address phase
// ----------------------------------------------------------------
`define RB_ADDR_W      8
`define RB_ADDR_CNT_W  4
`define RB_ADDR_WR     8'hA2
`define RB_ADDR_RD     8'hA3

// ----------------------------------------------------------------
// Block store
// ----------------------------------------------------------------
`define RB_DATA_W      16
`define RB_PTR_W       5
`define RB_DEPTH       5'h18
`define RB_LAST_IDX    5'h17
`define RB_THR_ONE     5'h01
`define RB_THR_HIGH    5'h0C
`define RB_FIFO_DEPTH  4
`define RB_FIFO_AW     2

// ----------------------------------------------------------------
// Readout frame: two flag bits then the block, MSB first
// ----------------------------------------------------------------
`define RB_FRAME_W     18
`define RB_BIT_CNT_W   5
`define RB_LAST_BIT    5'h11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RB_CLK_NS      8
`define RB_TDO_NS      265000
`define RB_TDO_CYC     ((`RB_TDO_NS + `RB_CLK_NS - 1) / `RB_CLK_NS)
`define RB_TMR_W       16

`endif

/* File: rdsbuf_properties.sv */
// Purpose: Timing checks on request line and store level
// Assumes: Line is low while oe is high; pins sampled by clk
// Notes:   Windows leave a few clocks for pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module rdsbuf_props #(
    parameter TDO_CYC = 50
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Serial pins
    input wire logic        transfer_enable,
    input wire logic        serial_shift_clock,
    input wire logic        serial_input_line,
    input wire logic        request_line_o,
    input wire logic        request_line_oe,
    // Block stream
    input wire logic        blk_valid,
    input wire logic [15:0] blk_data,
    input wire logic        blk_ready,
    // Status and straps
    input wire logic        osc_running,
    input wire logic        sync_reset,
    input wire logic        sync_found,
    input wire logic        request_threshold_select_low,
    input wire logic        request_threshold_select_high,
    input wire logic [4:0]  level_out
);
    default clocking cb @(posedge clk); endclocking
    logic [4:0]  thr;
    logic        rel_reg;
    logic        unsync_reg;
    logic [15:0] rel_cnt;
    assign thr = (request_threshold_select_low &&
                  request_threshold_select_high) ? 5'h0C : 5'h01;
    // Release runs from strobe fall until the line is pulled again
    always @(posedge clk) begin
        if (!nrst) begin
            rel_reg    <= 1'b0;
            unsync_reg <= 1'b1;
            rel_cnt    <= 16'h0000;
        end else begin
            if ($fell(transfer_enable)) begin
                rel_reg <= 1'b1;
                rel_cnt <= 16'h0000;
            end else if ($rose(request_line_oe) || sync_found) begin
                rel_reg <= 1'b0;
            end else if (rel_cnt != 16'hFFFF) begin
                rel_cnt <= rel_cnt + 16'h0001;
            end
            if (sync_found) unsync_reg <= 1'b0;
            else if (sync_reset) unsync_reg <= 1'b1;
        end
    end
    a_depth_max: assert property (disable iff (!nrst)
        level_out <= 5'h18) else $error("store level above 24");
    a_open_drain: assert property (disable iff (!nrst)
        request_line_o == 1'b0) else $error("line driven high");
    a_req_raise: assert property (disable iff (!nrst)
        (!unsync_reg && !rel_reg && !transfer_enable && level_out >= thr)[*3]
        |-> request_line_oe) else $error("stored block not requested");
    a_release_min: assert property (disable iff (!nrst)
        $rose(request_line_oe) && rel_reg && !transfer_enable
        |-> rel_cnt >= TDO_CYC) else $error("release interval short");
    a_release_end: assert property (disable iff (!nrst)
        rel_reg && !transfer_enable && rel_cnt == TDO_CYC + 12
        && level_out >= thr |-> request_line_oe)
        else $error("line not pulled after release");
    a_below_thr: assert property (disable iff (!nrst)
        rel_reg && rel_cnt > 8 && !transfer_enable && level_out < thr
        && $past(level_out) < thr |-> !request_line_oe)
        else $error("request below threshold");
    a_sync_hold: assert property (disable iff (!nrst)
        unsync_reg && $past(unsync_reg) && !transfer_enable &&
        !$past(transfer_enable, 4) |-> !request_line_oe)
        else $error("request while unsynchronised");
    a_sync_raise: assert property (disable iff (!nrst)
        sync_found && !transfer_enable |-> ##[1:3] request_line_oe)
        else $error("no request at synchronisation");
    a_osc_ignore: assert property (disable iff (!nrst)
        (!osc_running)[*8] && transfer_enable |-> $stable(request_line_oe))
        else $error("bus answered without oscillator");
endmodule // rdsbuf_props
bind rdsbuf_top rdsbuf_props #(.TDO_CYC(TDO_CYC)) i_props (
    .clk(clk), .nrst(nrst), .transfer_enable(transfer_enable),
    .serial_shift_clock(serial_shift_clock),
    .serial_input_line(serial_input_line), .request_line_o(request_line_o),
    .request_line_oe(request_line_oe), .blk_valid(blk_valid),
    .blk_data(blk_data), .blk_ready(blk_ready), .osc_running(osc_running),
    .sync_reset(sync_reset), .sync_found(sync_found),
    .request_threshold_select_low(request_threshold_select_low),
    .request_threshold_select_high(request_threshold_select_high),
    .level_out(level_out));
`default_nettype wire

/* File: rdsbuf_host_model.sv */
// Purpose: Controlling host on the three-wire bus
// Assumes: Pull-up on the request line, link clock idle low
// Notes:   Half link period is five core clocks (80 ns period)
`timescale 1ns/1ps
`default_nettype none
module rdsbuf_host_model (
    // Core clock for pacing
    input wire logic clk,
    // Bus pins
    output logic     transfer_enable,
    output logic     serial_shift_clock,
    output logic     serial_input_line,
    input wire logic request_line_o,
    input wire logic request_line_oe
);
    logic line;
    assign line = request_line_oe ? request_line_o : 1'b1;
    initial begin
        transfer_enable    = 1'b0;
        serial_shift_clock = 1'b0;
        serial_input_line  = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Address LSB first, then bits sampled late in the high phase
    task automatic xfer(input logic [7:0] a, input int n,
                        output logic [71:0] bits);
        bits = '0;
        for (int i = 0; i < 8; i++) begin
            serial_input_line = a[i];
            hw(5);
            serial_shift_clock = 1'b1;
            hw(5);
            serial_shift_clock = 1'b0;
        end
        serial_input_line = ~serial_input_line;
        hw(5);
        transfer_enable = 1'b1;
        hw(25);
        for (int b = 0; b < n; b++) begin
            serial_shift_clock = 1'b1;
            serial_input_line  = ~serial_input_line;
            hw(4);
            bits = {bits[70:0], line};
            hw(1);
            serial_shift_clock = 1'b0;
            hw(5);
        end
        transfer_enable   = 1'b0;
        serial_input_line = ~serial_input_line;
        hw(5);
    endtask
endmodule // rdsbuf_host_model
`default_nettype wire

/* File: rds_buffer_serial_readout_tb.sv */
// Purpose: Self-checking bench for the block buffer readout
// Assumes: Host model drives the bus, blocks driven here
// Notes:   Release shortened to 200 clocks, longer than an address phase
`timescale 1ns/1ps
`default_nettype none
module rds_buffer_serial_readout_tb;
    localparam int TDO = 200;
    logic        clk = 1'b0;
    logic        nrst, blk_valid, osc_running, sync_reset, sync_found;
    logic        thr_lo, thr_hi, blk_ready, req_o, req_oe, ten, sck, sdi;
    logic [15:0] blk_data;
    logic [4:0]  level_out;
    logic [15:0] mq[$];
    logic [71:0] bits;
    logic [7:0]  addrs [4] = '{8'hA2, 8'hA1, 8'h53, 8'hC5};
    int          n_fail = 0;
    int          n_checks = 0;
    int          seed = 32'h2A83295E;
    always #4 clk = ~clk;
    rdsbuf_top #(.TDO_CYC(TDO)) i_dut (.clk(clk), .nrst(nrst),
        .transfer_enable(ten), .serial_shift_clock(sck),
        .serial_input_line(sdi), .request_line_o(req_o),
        .request_line_oe(req_oe), .blk_valid(blk_valid),
        .blk_data(blk_data), .blk_ready(blk_ready),
        .osc_running(osc_running), .sync_reset(sync_reset),
        .sync_found(sync_found), .request_threshold_select_low(thr_lo),
        .request_threshold_select_high(thr_hi), .level_out(level_out));
    rdsbuf_host_model i_host (.clk(clk), .transfer_enable(ten),
        .serial_shift_clock(sck), .serial_input_line(sdi),
        .request_line_o(req_o), .request_line_oe(req_oe));
    always @(posedge clk) if (nrst && blk_valid && blk_ready) mq.push_back(blk_data);
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lvl();
        w(10);
        chk(level_out, 18'((mq.size() > 24) ? 24 : mq.size()));
    endtask
    // Offer n blocks; ready is registered, so look at it off the edge;
    // a refused block is held unchanged until taken or the 100-clock limit ends the offer
    task automatic push(input int n);
        int k;
        int g;
        bit nd;
        k = 0;
        g = 0;
        nd = 1'b1;
        while (k < n && g < 100) begin
            @(negedge clk);
            blk_valid = 1'b1;
            if (nd) blk_data = 16'($random(seed));
            nd = blk_ready;
            if (blk_ready) k++;
            g++;
        end
        @(negedge clk);
        blk_valid = 1'b0;
    endtask
    task automatic pulse(input bit f);
        @(negedge clk);
        if (f) sync_found = 1'b1;
        else sync_reset = 1'b1;
        @(negedge clk);
        sync_found = 1'b0;
        sync_reset = 1'b0;
        w(4);
    endtask
    // Frame: empty flag, fill flag, block; zeros when nothing is owed
    task automatic rd(input int n, input bit req);
        logic [17:0] e;
        int r;
        i_host.xfer(8'hA3, 18 * n, bits);
        for (int f = 0; f < n; f++) begin
            e = 18'h00000;
            if (req && mq.size() > 0) begin
                e[15:0] = mq.pop_front();
                r = mq.size();
                e[17] = (r == 0);
                e[16] = (r >= 12);
            end
            chk(bits[18 * (n - 1 - f) +: 18], e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        final_report();
    end
    initial begin
        {nrst, blk_valid, sync_reset, sync_found, thr_lo, thr_hi} = '0;
        blk_data = 16'h0000;
        osc_running = 1'b1;
        w(12);
        nrst = 1'b1;
        push(3);
        lvl();
        chk(req_oe, 1'b0);
        pulse(1'b1);
        chk(req_oe, 1'b1);
        rd(1, 1'b1);
        w(10);
        chk(req_oe, 1'b0);
        w(TDO - 20);
        chk(req_oe, 1'b0);
        w(40);
        chk(req_oe, 1'b1);
        rd(1, 1'b1);
        rd(1, 1'b0);
        w(TDO + 40);
        chk(req_oe, 1'b1);
        rd(3, 1'b1);
        w(TDO + 40);
        chk(req_oe, 1'b0);
        push(2);
        w(10);
        chk(req_oe, 1'b1);
        foreach (addrs[i]) begin
            i_host.xfer(addrs[i], 18, bits);
            lvl();
        end
        w(TDO + 40);
        osc_running = 1'b0;
        w(10);
        i_host.xfer(8'hA3, 36, bits);
        lvl();
        osc_running = 1'b1;
        w(TDO + 40);
        rd(2, 1'b1);
        {thr_lo, thr_hi} = 2'h3;
        w(TDO + 40);
        push(11);
        w(10);
        chk(req_oe, 1'b0);
        push(1);
        w(10);
        chk(req_oe, 1'b1);
        push(40);
        lvl();
        chk(18'(mq.size()), 18'h0001C);
        chk(blk_ready, 1'b0);
        rd(2, 1'b1);
        lvl();
        w(TDO + 40);
        pulse(1'b0);
        chk(req_oe, 1'b0);
        pulse(1'b1);
        chk(req_oe, 1'b1);
        final_report();
    end
endmodule // rds_buffer_serial_readout_tb
`default_nettype wire
